// [rtl/dual_port_peripheral_adapter.sv]
// Purpose: two-section peripheral adapter behind an 8-bit strobed host bus
// Assumes: phase_two and all pins synchronous to clk; init_low sampled as async reset too
// Notes: phase_two high marks the transfer window
// Notes on behaviour
// - access only when both high selects high and the low select low.
// - host data lines not driven while unselected.
// - read/write high reads the addressed register, low writes it.
// - pick 00 is port A data or direction per bit 2; 01 control A.
// - pick 10 is port B data or direction per bit 2; 11 control B.
// - control bits 7 and 6 flag activity on the two handshake lines.
// - interrupt outputs are open drain, low while an enabled flag is pending.
// - reset clears control, direction and data registers (aux levels reset high) and makes every port line an input.
// - write byte is caught into a holding latch during phase two.
// - held byte lands in its target only after phase two falls.
// - each port line separately input or output.
// - section B mirrors A except port read and aux pulse; bus buffer, latch and decode are shared.
// - control bits steer edge sensing on both lines and aux line output.
// - direction 0 is input, 1 drives from the output latch.
// - active edges set bits 7 and 6; port data read clears both.
// - interrupt low when bit7 and bit0 are set, or bit6 and bit3 are set with bit5 clear.
// - port A read gives pins; port B gives latch on outputs, pins on inputs.
`include "pia_consts.svh"
`default_nettype none
module dual_port_peripheral_adapter (
	input wire logic clk,
	input wire logic rst,
	input wire logic init_low,
	input wire logic phase_two,
	input wire logic select_high_first,
	input wire logic select_high_second,
	input wire logic select_low_third,
	input wire logic reg_pick_low,
	input wire logic reg_pick_high,
	input wire logic read_write,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic [7:0] host_data_oe_n,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe_n,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe_n,
	input wire logic section_a_event_line,
	input wire logic section_a_aux_in,
	output logic section_a_aux_out,
	output logic section_a_aux_oe_n,
	input wire logic section_b_event_line,
	input wire logic section_b_aux_in,
	output logic section_b_aux_out,
	output logic section_b_aux_oe_n,
	output logic section_a_int_out,
	output logic section_a_int_oe_n,
	output logic section_b_int_out,
	output logic section_b_int_oe_n
);
	////////////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic [7:0] port_read(input logic [7:0] pins, input logic [7:0] lat,
		input logic [7:0] dir, input logic use_latch);
		port_read = use_latch ? ((lat & dir) | (pins & ~dir)) : pins;
	endfunction
	function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
		edge_hit = rising ? (!prev && now) : (prev && !now);
	endfunction
	function automatic logic int_req(input logic [7:0] c);
		int_req = (c[`CTL_FLAG1] & c[`CTL_EN1]) |
			(c[`CTL_FLAG2] & c[`CTL_EN2] & ~c[`CTL_AUX_DIR]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// host request decode
	pia_pkg::host_req_t req;
	wire chip_sel = select_high_first & select_high_second & ~select_low_third;
	assign req.sel = chip_sel;
	assign req.rd = read_write;
	assign req.pick = {reg_pick_high, reg_pick_low};
	assign req.data = host_data_in;
	wire rst_all = rst | ~init_low;

	logic [7:0] ctl_a_q;
	logic [7:0] ctl_b_q;
	logic [7:0] dir_a_q;
	logic [7:0] dir_b_q;
	logic [7:0] lat_a_q;
	logic [7:0] lat_b_q;
	logic [7:0] hold_q;
	logic [1:0] hold_pick_q;
	logic p2_q;
	logic aux_a_q;
	logic aux_b_q;
	logic ev_a_q;
	logic ev_b_q;
	logic axi_a_q;
	logic axi_b_q;
	pia_pkg::wr_phase_t ph_q;

	wire xfer = phase_two & req.sel;
	wire p2_fall = p2_q & ~phase_two;
	// the read strobe fires on the fall so a read clears flags exactly once per pulse
	wire rd_strobe = p2_fall & req.sel & req.rd;
	wire wr_catch = xfer & ~req.rd;
	wire commit = (ph_q == pia_pkg::PH_HOLD) & ~phase_two;
	wire [1:0] cp = hold_pick_q;
	wire rd_a_data = rd_strobe & (req.pick == `PICK_A_DATA) & ctl_a_q[`CTL_SEL_DATA];
	wire rd_b_data = rd_strobe & (req.pick == `PICK_B_DATA) & ctl_b_q[`CTL_SEL_DATA];
	wire wa_data = commit & (cp == `PICK_A_DATA);
	wire wb_data = commit & (cp == `PICK_B_DATA);
	wire wa_ctl = commit & (cp == `PICK_A_CTRL);
	wire wb_ctl = commit & (cp == `PICK_B_CTRL);

	////////////////////////////////////////////////////////////////////////////
	// handshake sensing, flags set win over read clear
	wire hit1_a = edge_hit(ev_a_q, section_a_event_line, ctl_a_q[`CTL_EDGE1]);
	wire hit1_b = edge_hit(ev_b_q, section_b_event_line, ctl_b_q[`CTL_EDGE1]);
	wire hit2_a = ~ctl_a_q[`CTL_AUX_DIR] &
		edge_hit(axi_a_q, section_a_aux_in, ctl_a_q[`CTL_EDGE2]);
	wire hit2_b = ~ctl_b_q[`CTL_AUX_DIR] &
		edge_hit(axi_b_q, section_b_aux_in, ctl_b_q[`CTL_EDGE2]);
	wire [7:0] wctl_a = wa_ctl ? (hold_q & `CTL_WMASK) : (ctl_a_q & `CTL_WMASK);
	wire [7:0] wctl_b = wb_ctl ? (hold_q & `CTL_WMASK) : (ctl_b_q & `CTL_WMASK);
	wire f1_a = hit1_a | (ctl_a_q[`CTL_FLAG1] & ~rd_a_data);
	wire f2_a = hit2_a | (ctl_a_q[`CTL_FLAG2] & ~rd_a_data);
	wire f1_b = hit1_b | (ctl_b_q[`CTL_FLAG1] & ~rd_b_data);
	wire f2_b = hit2_b | (ctl_b_q[`CTL_FLAG2] & ~rd_b_data);
	wire [7:0] ctl_a_d = {f1_a, f2_a, wctl_a[5:0]};
	wire [7:0] ctl_b_d = {f1_b, f2_b, wctl_b[5:0]};

	// aux line as output: bit 4 manual level, else pulse low after a data access (section B: after a data write only)
	wire aux_a_d = ctl_a_q[`CTL_EDGE2] ? ctl_a_q[`CTL_AUX_PULSE] :
		((rd_a_data | (wa_data & ctl_a_q[`CTL_SEL_DATA])) ? 1'b0 :
		(hit1_a | ctl_a_q[`CTL_AUX_PULSE]) ? 1'b1 : aux_a_q);
	wire aux_b_d = ctl_b_q[`CTL_EDGE2] ? ctl_b_q[`CTL_AUX_PULSE] :
		((wb_data & ctl_b_q[`CTL_SEL_DATA]) ? 1'b0 :
		(hit1_b | ctl_b_q[`CTL_AUX_PULSE]) ? 1'b1 : aux_b_q);

	wire [7:0] rd_mux =
		(req.pick == `PICK_A_DATA) ? (ctl_a_q[`CTL_SEL_DATA] ?
			port_read(port_a_in, lat_a_q, dir_a_q, 1'b0) : dir_a_q) :
		(req.pick == `PICK_A_CTRL) ? ctl_a_q :
		(req.pick == `PICK_B_DATA) ? (ctl_b_q[`CTL_SEL_DATA] ?
			port_read(port_b_in, lat_b_q, dir_b_q, 1'b1) : dir_b_q) : ctl_b_q;
	wire drive_bus = xfer & req.rd;

	////////////////////////////////////////////////////////////////////////////
	// shared write path
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			ph_q <= pia_pkg::PH_IDLE;
			hold_q <= `BYTE_RESET;
			hold_pick_q <= 2'h0;
			p2_q <= 1'b0;
		end else begin
			p2_q <= phase_two;
			if (wr_catch) begin
				hold_q <= req.data;
				hold_pick_q <= req.pick;
				ph_q <= pia_pkg::PH_HOLD;
			end else if (commit) begin
				ph_q <= pia_pkg::PH_IDLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// section registers
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			ctl_a_q <= `BYTE_RESET;
			ctl_b_q <= `BYTE_RESET;
			dir_a_q <= `BYTE_RESET;
			dir_b_q <= `BYTE_RESET;
			lat_a_q <= `BYTE_RESET;
			lat_b_q <= `BYTE_RESET;
			ev_a_q <= 1'b0;
			ev_b_q <= 1'b0;
			axi_a_q <= 1'b0;
			axi_b_q <= 1'b0;
			aux_a_q <= 1'b1;
			aux_b_q <= 1'b1;
		end else begin
			ev_a_q <= section_a_event_line;
			ev_b_q <= section_b_event_line;
			axi_a_q <= section_a_aux_in;
			axi_b_q <= section_b_aux_in;
			ctl_a_q <= ctl_a_d;
			ctl_b_q <= ctl_b_d;
			aux_a_q <= aux_a_d;
			aux_b_q <= aux_b_d;
			if (wa_data && ctl_a_q[`CTL_SEL_DATA]) lat_a_q <= hold_q;
			if (wa_data && !ctl_a_q[`CTL_SEL_DATA]) dir_a_q <= hold_q;
			if (wb_data && ctl_b_q[`CTL_SEL_DATA]) lat_b_q <= hold_q;
			if (wb_data && !ctl_b_q[`CTL_SEL_DATA]) dir_b_q <= hold_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered pins
	always_ff @(posedge clk or posedge rst_all) begin
		if (rst_all) begin
			host_data_out <= 8'h00;
			host_data_oe_n <= 8'hff;
			port_a_out <= 8'h00;
			port_a_oe_n <= 8'hff;
			port_b_out <= 8'h00;
			port_b_oe_n <= 8'hff;
			section_a_aux_out <= 1'b1;
			section_a_aux_oe_n <= 1'b1;
			section_b_aux_out <= 1'b1;
			section_b_aux_oe_n <= 1'b1;
			section_a_int_out <= 1'b0;
			section_a_int_oe_n <= 1'b1;
			section_b_int_out <= 1'b0;
			section_b_int_oe_n <= 1'b1;
		end else begin
			host_data_out <= rd_mux;
			host_data_oe_n <= {8{~drive_bus}};
			port_a_out <= lat_a_q;
			port_a_oe_n <= ~dir_a_q;
			port_b_out <= lat_b_q;
			port_b_oe_n <= ~dir_b_q;
			section_a_aux_out <= aux_a_q;
			section_a_aux_oe_n <= ~ctl_a_q[`CTL_AUX_DIR];
			section_b_aux_out <= aux_b_q;
			section_b_aux_oe_n <= ~ctl_b_q[`CTL_AUX_DIR];
			section_a_int_oe_n <= ~int_req(ctl_a_q);
			section_b_int_oe_n <= ~int_req(ctl_b_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst_all);
	a_bus_unsel_float: assert property (!chip_sel |=> host_data_oe_n == 8'hff)
		else $error("data bus driven while unselected");
	a_int_a_follow: assert property (##1 section_a_int_oe_n == !int_req($past(ctl_a_q)))
		else $error("section a interrupt wrong");
	a_flag_set_edge: assert property (hit1_a |=> ctl_a_q[`CTL_FLAG1])
		else $error("event flag a not set");
	a_flag_read_clr: assert property (rd_b_data && !hit1_b |=> !ctl_b_q[`CTL_FLAG1])
		else $error("flag b not cleared by read");
	a_commit_after_fall: assert property (wr_catch |-> !commit)
		else $error("commit during phase two");
	a_write_lands: assert property (wr_catch && req.pick == `PICK_A_CTRL ##1 !phase_two
		|=> ctl_a_q[5:0] == $past(hold_q[5:0]))
		else $error("control a write lost");
	a_dir_drives: assert property (##1 port_b_oe_n == ~$past(dir_b_q))
		else $error("port b direction wrong");
	a_read_drives: assert property (xfer && req.rd |=> host_data_oe_n == 8'h00)
		else $error("read not driven");
	c_read_a: cover property (rd_a_data);
	c_write_b: cover property (wb_data);
	c_int_b: cover property (!section_b_int_oe_n);
	c_aux_flag_a: cover property (hit2_a);
	c_write_ctl_a: cover property (wa_ctl);

	////////////////////////////////////////////////////////////////////////////
	// more checks, section b mirrors section a except port read and aux pulse
	a_int_b_follow: assert property (##1 section_b_int_oe_n == !int_req($past(ctl_b_q)))
		else $error("section b interrupt wrong");
	a_int_a_low: assert property (section_a_int_out == 1'b0)
		else $error("interrupt a drives high");
	a_dir_a_drives: assert property (##1 port_a_oe_n == ~$past(dir_a_q))
		else $error("port a direction wrong");
	a_lat_a_out: assert property (##1 port_a_out == $past(lat_a_q))
		else $error("port a output wrong");
	a_lat_b_out: assert property (##1 port_b_out == $past(lat_b_q))
		else $error("port b output wrong");

	a_flag_a_clr: assert property (rd_a_data && !hit1_a |=> !ctl_a_q[`CTL_FLAG1])
		else $error("flag a not cleared by read");
	a_flag2_a_clr: assert property (rd_a_data && !hit2_a |=> !ctl_a_q[`CTL_FLAG2])
		else $error("aux flag a not cleared by read");
	a_flag_b_set: assert property (hit1_b |=> ctl_b_q[`CTL_FLAG1])
		else $error("event flag b not set");
	a_flag2_a_set: assert property (hit2_a |=> ctl_a_q[`CTL_FLAG2])
		else $error("aux flag a not set");
	a_flag2_b_set: assert property (hit2_b |=> ctl_b_q[`CTL_FLAG2])
		else $error("aux flag b not set");

	a_catch_sel: assert property (wr_catch |-> chip_sel)
		else $error("write caught while unselected");
	a_wr_no_drive: assert property (xfer && !req.rd |=> host_data_oe_n == 8'hff)
		else $error("bus driven during write");
	a_rd_value: assert property (xfer && req.rd |=> host_data_out == $past(rd_mux))
		else $error("read byte wrong");
	a_aux_a_dir: assert property (##1 section_a_aux_oe_n == !$past(ctl_a_q[`CTL_AUX_DIR]))
		else $error("aux a direction wrong");
	a_aux_b_dir: assert property (##1 section_b_aux_oe_n == !$past(ctl_b_q[`CTL_AUX_DIR]))
		else $error("aux b direction wrong");
	a_write_lands_b: assert property (wr_catch && req.pick == `PICK_B_CTRL ##1 !phase_two
		|=> ctl_b_q[5:0] == $past(hold_q[5:0]))
		else $error("control b write lost");
endmodule // dual_port_peripheral_adapter
`default_nettype wire

// [rtl/pia_consts.svh]
// Purpose: offsets, field positions and reset values of the adapter
// Assumes: included once per compile unit
// Notes: register picks are two-bit codes on reg_pick_high/reg_pick_low
`ifndef PIA_CONSTS_SVH
`define PIA_CONSTS_SVH
`define PICK_A_DATA 2'h0
`define PICK_A_CTRL 2'h1
`define PICK_B_DATA 2'h2
`define PICK_B_CTRL 2'h3
`define CTL_FLAG1 7
`define CTL_FLAG2 6
`define CTL_AUX_DIR 5
`define CTL_AUX_HI 5
`define CTL_AUX_LO 3
`define CTL_EN2 3
`define CTL_SEL_DATA 2
`define CTL_EDGE1 1
`define CTL_EN1 0
`define CTL_EDGE2 4
`define CTL_AUX_PULSE 3
`define CTL_WMASK 8'h3f
`define BYTE_RESET 8'h00
`endif

// [rtl/pia_pkg.sv]
// Purpose: types shared by the adapter
// Assumes: nothing
// Notes: one struct per host access
`default_nettype none
package pia_pkg;
	typedef struct packed {
		logic sel;
		logic rd;
		logic [1:0] pick;
		logic [7:0] data;
	} host_req_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_HOLD = 2'b10
	} wr_phase_t;
endpackage
`default_nettype wire

// [dv/host_bus_model.sv]
// Purpose: host processor side of the adapter's strobed bus
// Assumes: clk shared with the adapter; tasks called from the bench
// Notes: a released data bus shows the inverted byte, never the last one
`default_nettype none
module host_bus_model (
	input wire logic clk,
	output logic phase_two,
	output logic [2:0] sel,
	output logic [1:0] pick,
	output logic read_write,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out,
	input wire logic [7:0] host_data_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ok = 1'b1;
	initial begin
		phase_two = 1'b0;
		sel = 3'h4;
		pick = 2'h0;
		read_write = 1'b1;
		host_data_in = 8'h00;
	end
	// selects settle one cycle before the strobe
	task automatic open_cycle(input logic [1:0] p);
		@(posedge clk);
		sel <= {1'b1, ok, 1'b0};
		pick <= p;
		@(posedge clk);
		phase_two <= 1'b1;
	endtask
	task automatic wr(input logic [1:0] p, input logic [7:0] d);
		open_cycle(p);
		read_write <= 1'b0;
		host_data_in <= d;
		@(posedge clk);
		phase_two <= 1'b0;
		host_data_in <= ~d;
		@(posedge clk);
		read_write <= 1'b1;
		sel <= 3'h4;
		repeat (3) @(posedge clk);
	endtask
	task automatic rd(input logic [1:0] p, output logic [7:0] q, output logic [7:0] oe);
		open_cycle(p);
		@(posedge clk);
		phase_two <= 1'b0;
		#1;
		q = host_data_out;
		oe = host_data_oe_n;
		@(posedge clk);
		sel <= 3'h4;
		repeat (3) @(posedge clk);
	endtask
endmodule // host_bus_model
`default_nettype wire

// [dv/test_dual_port_peripheral_adapter.sv]
// Purpose: self-checking bench for the two-section adapter
// Assumes: host_bus_model drives the processor bus
// Notes: both sections run through one loop; only the port B data read expects latch bits on outputs
`default_nettype none
module test_dual_port_peripheral_adapter;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic init_low = 1'b1;
	logic [7:0] pin [2] = '{8'h3c, 8'hc3};
	logic [1:0] ev = 2'h0;
	logic [1:0] aux = 2'h0;
	logic p2, rw;
	logic [2:0] sel;
	logic [1:0] pick, irq_n;
	logic [7:0] hd_in, hd_out, hd_oe_n, q, oe;
	logic [7:0] out [2];
	logic [7:0] dir_n [2];
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	host_bus_model u_host_bus_model (.clk(clk), .phase_two(p2), .sel(sel), .pick(pick),
		.read_write(rw), .host_data_in(hd_in), .host_data_out(hd_out),
		.host_data_oe_n(hd_oe_n));
	dual_port_peripheral_adapter u_dual_port_peripheral_adapter (.clk(clk), .rst(rst),
		.init_low(init_low), .phase_two(p2), .select_high_first(sel[2]),
		.select_high_second(sel[1]), .select_low_third(sel[0]), .reg_pick_low(pick[0]),
		.reg_pick_high(pick[1]), .read_write(rw), .host_data_in(hd_in),
		.host_data_out(hd_out), .host_data_oe_n(hd_oe_n), .port_a_in(pin[0]),
		.port_a_out(out[0]), .port_a_oe_n(dir_n[0]), .port_b_in(pin[1]),
		.port_b_out(out[1]), .port_b_oe_n(dir_n[1]), .section_a_event_line(ev[0]),
		.section_a_aux_in(aux[0]), .section_a_aux_out(), .section_a_aux_oe_n(),
		.section_b_event_line(ev[1]), .section_b_aux_in(aux[1]), .section_b_aux_out(),
		.section_b_aux_oe_n(), .section_a_int_out(), .section_a_int_oe_n(irq_n[0]),
		.section_b_int_out(), .section_b_int_oe_n(irq_n[1]));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// a hang costs a mismatch rather than an endless run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(hd_oe_n, 8'hff);
		chk(dir_n[0] & dir_n[1], 8'hff);
		chk({6'h0, irq_n}, 8'h03);
	endtask
	task automatic t_select();
		u_host_bus_model.ok = 1'b0;
		u_host_bus_model.wr(2'h1, 8'h04);
		u_host_bus_model.rd(2'h1, q, oe);
		chk(oe, 8'hff);
		u_host_bus_model.ok = 1'b1;
		u_host_bus_model.rd(2'h1, q, oe);
		chk(oe, 8'h00);
		chk(q, 8'h00);
	endtask
	task automatic t_port(input int s);
		logic [1:0] pd;
		pd = {s[0], 1'b0};
		u_host_bus_model.wr(pd, 8'h0f);
		u_host_bus_model.rd(pd, q, oe);
		chk(q, 8'h0f);
		chk(dir_n[s], 8'hf0);
		u_host_bus_model.wr(pd | 2'h1, 8'hc4);
		u_host_bus_model.rd(pd | 2'h1, q, oe);
		chk(q, 8'h04);
		u_host_bus_model.wr(pd, 8'ha5);
		chk(out[s], 8'ha5);
		u_host_bus_model.rd(pd, q, oe);
		chk(q, s ? 8'h05 | (pin[1] & 8'hf0) : pin[0]);
	endtask
	task automatic t_flags(input int s);
		logic [1:0] pc;
		pc = {s[0], 1'b1};
		@(posedge clk) ev[s] <= 1'b1;
		repeat (3) @(posedge clk);
		chk({7'h0, irq_n[s]}, 8'h01);
		u_host_bus_model.rd(pc, q, oe);
		chk(q, 8'h04);
		u_host_bus_model.rd(pc & 2'h2, q, oe);
		ev[s] <= 1'b0;
		repeat (3) @(posedge clk);
		u_host_bus_model.rd(pc, q, oe);
		chk(q, 8'h84);
		u_host_bus_model.wr(pc, 8'h1f);
		@(posedge clk) ev[s] <= 1'b1;
		repeat (3) @(posedge clk);
		chk({7'h0, irq_n[s]}, 8'h00);
		@(posedge clk) aux[s] <= 1'b1;
		u_host_bus_model.rd(pc, q, oe);
		chk(q, 8'hdf);
		u_host_bus_model.rd(pc & 2'h2, q, oe);
		u_host_bus_model.rd(pc, q, oe);
		chk(q, 8'h1f);
		chk({7'h0, irq_n[s]}, 8'h01);
	endtask
	task automatic t_init();
		@(posedge clk) init_low <= 1'b0;
		@(posedge clk) init_low <= 1'b1;
		#1;
		chk(dir_n[0] & dir_n[1], 8'hff);
		u_host_bus_model.rd(2'h3, q, oe);
		chk(q, 8'h00);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_select();
		for (int s = 0; s < 2; s++) begin
			t_port(s);
			t_flags(s);
		end
		t_init();
		results();
	end
endmodule // test_dual_port_peripheral_adapter
`default_nettype wire
